// [hw/prta_pkg.sv]
/*
 Constants, field layouts and types for the per-port packet rule table.
 Assumes one switch core clock and a host register port decoded upstream.
*/
// Notes on behaviour
// - Five ports, each with its own table of sixteen rule entries.
// - Indirect address is port nibble as bits 11..8 plus offset byte.
// - Offsets zero to thirteen map to entry bytes thirteen downward.
// - Offsets fourteen and fifteen are reserved with no function.
// - Offsets sixteen and seventeen hold the per-byte enable mask.
// - Offset eighteen is the entry transfer control and status byte.
// - Table chosen by select code 010, port 1..5, data via 0xA0.
// - Offset zero low nibble names the entry whose action applies.
// - Rules combine into rule sets through offsets twelve and thirteen.
// - Two-bit kind: off, station header, network address, transport.
// - Station kind with compare 00 counts packets in us or ms units.
// - Count-down timer reloads on hits, flags an event on expiry.
// - Count-up mode counts hits, flags event at limit, then clears.
// - Station compare 01 address, 10 frame kind, 11 both.
// - Network compare 01 address or protocol, 10 source vs dest. Here both are decoded but never match.
// - Transport compare 00 protocol, 01/10 ports, 11 sequence number. Here all are decoded but never match.
// - Address select bit: zero destination, one source.
// - Polarity bit: zero matches on differ, one matches on equal.
// - Station address bytes 2..7 and frame kind bytes 8..9, high first.
// - Writing control register one triggers; control zero bit 4 is read. Here it starts reads only; writes trigger on the data byte write.
package prta_pkg;
	// Host register addresses
	localparam logic [7:0] PRTA_CTRL0_ADDR = 8'h6E;
	localparam logic [7:0] PRTA_CTRL1_ADDR = 8'h6F;
	localparam logic [7:0] PRTA_DATA_ADDR = 8'hA0;
	// Control register zero fields
	localparam logic [2:0] PRTA_TABLE_SEL = 3'h2;
	localparam int PRTA_SEL_LSB = 5;
	localparam int PRTA_RD_BIT = 4;
	// Indirect offsets
	localparam int PRTA_ENTRY_BYTES = 14;
	localparam logic [7:0] PRTA_OFF_FIRST = 8'h00;
	localparam logic [7:0] PRTA_OFF_MODE = 8'h01;
	localparam logic [7:0] PRTA_OFF_ADDR = 8'h02;
	localparam logic [7:0] PRTA_OFF_KIND = 8'h08;
	localparam logic [7:0] PRTA_OFF_ACT_HI = 8'h0A;
	localparam logic [7:0] PRTA_OFF_ACT_LO = 8'h0B;
	localparam logic [7:0] PRTA_OFF_SET_HI = 8'h0C;
	localparam logic [7:0] PRTA_OFF_SET_LO = 8'h0D;
	localparam logic [7:0] PRTA_OFF_BE_HI = 8'h10;
	localparam logic [7:0] PRTA_OFF_BE_LO = 8'h11;
	localparam logic [7:0] PRTA_OFF_XFER = 8'h12;
	// Writable masks of the header bytes, reserved bits cleared
	localparam logic [7:0] PRTA_FIRST_MASK = 8'h0F;
	localparam logic [7:0] PRTA_MODE_MASK = 8'h3F;
	localparam logic [7:0] PRTA_RESET_BYTE = 8'h00;
	// Transfer byte fields
	localparam int PRTA_XFER_WR_BIT = 4;
	localparam int PRTA_XFER_BUSY_BIT = 5;
	// Mode byte fields
	localparam int PRTA_KIND_LSB = 4;
	localparam int PRTA_CMP_LSB = 2;
	localparam int PRTA_SRC_BIT = 1;
	localparam int PRTA_POL_BIT = 0;
	localparam logic [1:0] PRTA_KIND_OFF = 2'h0;
	localparam logic [1:0] PRTA_KIND_STATION = 2'h1;
	localparam logic [1:0] PRTA_KIND_NETWORK = 2'h2;
	localparam logic [1:0] PRTA_KIND_TRANSPORT = 2'h3;
	localparam logic [1:0] PRTA_CMP_00 = 2'h0;
	localparam logic [1:0] PRTA_CMP_01 = 2'h1;
	localparam logic [1:0] PRTA_CMP_10 = 2'h2;
	localparam logic [1:0] PRTA_CMP_11 = 2'h3;
	// Action bytes: unit in ACT_HI[7], count-up in ACT_HI[6], count in {ACT_HI[2:0], ACT_LO}
	localparam int PRTA_UNIT_BIT = 7;
	localparam int PRTA_ALG_BIT = 6;
	localparam int PRTA_CNT_W = 11;
	// Timing
	localparam int PRTA_CLK_MHZ = 100;
	localparam int PRTA_UNIT_US = 1;
	localparam int PRTA_CLKS_PER_US = PRTA_UNIT_US * PRTA_CLK_MHZ;
	localparam int PRTA_US_PER_MS = 1000;
	// Sequencer states
	typedef enum logic [3:0] {
		PRTA_S_IDLE = 4'h1,
		PRTA_S_FETCH = 4'h2,
		PRTA_S_SCAN = 4'h4,
		PRTA_S_DRAIN = 4'h8
	} prta_state_t;
	// Decoded comparison
	typedef enum logic [3:0] {
		PRTA_C_NONE, PRTA_C_COUNT, PRTA_C_ADDR, PRTA_C_KIND, PRTA_C_BOTH,
		PRTA_C_IP_MASK, PRTA_C_IP_SA_DA, PRTA_C_PROTO, PRTA_C_PORTS, PRTA_C_SEQ
	} prta_cmp_t;
endpackage

// [hw/prta_entry_mem.sv]
/*
 Rule entry memory: one write port, one read port with registered data.
 Assumes the caller never needs read data in the same cycle as the address.
*/
`timescale 1ns/1ps
module prta_entry_mem #(
	parameter int WIDTH = 112,
	parameter int DEPTH = 80,
	parameter int AW = 7
) (
	// Clock
	input wire logic clk_sys,
	// Write side
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// Read side
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [0:DEPTH-1];

	initial begin
		if (DEPTH > (1 << AW)) $error("prta_entry_mem: DEPTH exceeds address range");
	end

	// Contents are never cleared, by reset or by the table logic, to stay RAM-like
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// Registered read
	always_ff @(posedge clk_sys) begin
		rd_data <= mem[rd_addr];
	end
endmodule

// [hw/prta_table.sv]
/*
 Per-port packet rule tables with indirect byte access and a lookup engine.
 Assumes a host register port decoded upstream and packets offered by the
 switch core with a valid/ready handshake, all on clk_sys.
*/
`timescale 1ns/1ps
module prta_table import prta_pkg::*; #(
	parameter int NPORT = 5,
	parameter int NRULE = 16,
	parameter int CLKS_PER_US = PRTA_CLKS_PER_US,
	parameter int US_PER_MS = PRTA_US_PER_MS
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Host register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Packet lookup request
	input wire logic pkt_valid,
	output logic pkt_ready,
	input wire logic [2:0] pkt_port,
	input wire logic [47:0] pkt_dst_addr,
	input wire logic [47:0] pkt_src_addr,
	input wire logic [15:0] pkt_frame_kind,
	// Lookup results and events
	output logic lookup_done,
	output logic lookup_hit,
	output logic [3:0] lookup_action_idx,
	output logic [NPORT-1:0] timer_event,
	output logic xfer_busy
);
	localparam int EW = PRTA_ENTRY_BYTES * 8;
	localparam int AW = $clog2(NPORT * NRULE);

	initial begin
		if (NRULE != 16 || NPORT < 1 || NPORT > 15 || CLKS_PER_US < 2 || US_PER_MS < 2)
			$error("prta_table: unsupported parameters");
	end

	logic [7:0] ctrl0_reg, ctrl1_reg, data_reg, rdata_reg;
	logic [EW-1:0] stage_reg;
	logic [15:0] be_reg;
	logic [3:0] xfer_idx_reg;
	logic xfer_wr_reg, xfer_pend_reg;
	prta_state_t state_reg;
	logic [AW-1:0] mem_raddr, mem_waddr;
	logic [EW-1:0] mem_rdata, merged;
	logic mem_we;
	logic [11:0] ind_addr;
	logic tbl_sel, port_ok, loc_wr;
	logic [3:0] scan_idx_reg, eval_idx_reg;
	logic eval_v_reg;
	logic [2:0] pk_port_reg;
	logic [47:0] pk_da_reg, pk_sa_reg;
	logic [15:0] pk_kind_reg;
	logic [NRULE-1:0] match_vec_reg;
	logic [15:0] set_mask_reg [0:NRULE-1];
	logic [3:0] frn_reg [0:NRULE-1];

	// Byte of the staged entry at an offset; offset 0 is entry byte 13
	function automatic logic [7:0] stage_byte(input logic [EW-1:0] s, input logic [7:0] off);
		stage_byte = s[(PRTA_ENTRY_BYTES - 1 - int'(off)) * 8 +: 8];
	endfunction

	// Readback of any indirect location
	function automatic logic [7:0] loc_read(input logic [7:0] off);
		if (off == PRTA_OFF_FIRST)
			loc_read = stage_byte(stage_reg, off) & PRTA_FIRST_MASK;
		else if (off == PRTA_OFF_MODE)
			loc_read = stage_byte(stage_reg, off) & PRTA_MODE_MASK;
		else if (off < 8'(PRTA_ENTRY_BYTES))
			loc_read = stage_byte(stage_reg, off);
		else if (off == PRTA_OFF_BE_HI)
			loc_read = be_reg[15:8];
		else if (off == PRTA_OFF_BE_LO)
			loc_read = be_reg[7:0];
		else if (off == PRTA_OFF_XFER)
			loc_read = {2'h0, xfer_pend_reg, xfer_wr_reg, xfer_idx_reg};
		else
			loc_read = PRTA_RESET_BYTE;
	endfunction

	// Indirect address and selection decode
	assign ind_addr = {ctrl0_reg[3:0], ctrl1_reg};
	assign tbl_sel = ctrl0_reg[7:PRTA_SEL_LSB] == PRTA_TABLE_SEL;
	assign port_ok = ctrl0_reg[3:0] >= 4'h1 && ctrl0_reg[3:0] <= 4'(NPORT);
	assign loc_wr = reg_wr && reg_addr == PRTA_DATA_ADDR && tbl_sel && !ctrl0_reg[PRTA_RD_BIT];

	// Control registers
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ctrl0_reg <= 8'h00;
			ctrl1_reg <= 8'h00;
		end else if (reg_wr && reg_addr == PRTA_CTRL0_ADDR) begin
			ctrl0_reg <= reg_wdata;
		end else if (reg_wr && reg_addr == PRTA_CTRL1_ADDR) begin
			ctrl1_reg <= reg_wdata;
		end
	end

	// Data byte: a read-mode trigger fetches the addressed location
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			data_reg <= 8'h00;
		end else if (reg_wr && reg_addr == PRTA_CTRL1_ADDR && tbl_sel && ctrl0_reg[PRTA_RD_BIT]) begin
			data_reg <= loc_read(reg_wdata);
		end else if (reg_wr && reg_addr == PRTA_DATA_ADDR) begin
			data_reg <= reg_wdata;
		end
	end

	// Host readback, one cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				PRTA_CTRL0_ADDR: rdata_reg <= ctrl0_reg;
				PRTA_CTRL1_ADDR: rdata_reg <= ctrl1_reg;
				PRTA_DATA_ADDR: rdata_reg <= data_reg;
				default: rdata_reg <= 8'h00;
			endcase
		end
	end
	assign reg_rdata = rdata_reg;

	// Staging buffer: host byte writes, and entry reads land here
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			stage_reg <= '0;
		end else if (state_reg == PRTA_S_FETCH && !xfer_wr_reg) begin
			stage_reg <= mem_rdata;
		end else if (loc_wr && ind_addr[7:0] < 8'(PRTA_ENTRY_BYTES)) begin
			if (ind_addr[7:0] == PRTA_OFF_FIRST)
				stage_reg[(PRTA_ENTRY_BYTES - 1) * 8 +: 8] <= reg_wdata & PRTA_FIRST_MASK;
			else if (ind_addr[7:0] == PRTA_OFF_MODE)
				stage_reg[(PRTA_ENTRY_BYTES - 2) * 8 +: 8] <= reg_wdata & PRTA_MODE_MASK;
			else
				stage_reg[(PRTA_ENTRY_BYTES - 1 - int'(ind_addr[7:0])) * 8 +: 8] <= reg_wdata;
		end
	end

	// Byte enables and transfer request; a request while one is pending, fetch cycle included, is dropped
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			be_reg <= 16'h0000;
			xfer_idx_reg <= 4'h0;
			xfer_wr_reg <= 1'b0;
			xfer_pend_reg <= 1'b0;
		end else begin
			if (loc_wr && ind_addr[7:0] == PRTA_OFF_BE_HI)
				be_reg[15:8] <= reg_wdata;
			if (loc_wr && ind_addr[7:0] == PRTA_OFF_BE_LO)
				be_reg[7:0] <= reg_wdata;
			if (state_reg == PRTA_S_FETCH)
				xfer_pend_reg <= 1'b0;
			if (loc_wr && ind_addr[7:0] == PRTA_OFF_XFER && port_ok && !xfer_pend_reg) begin
				xfer_idx_reg <= reg_wdata[3:0];
				xfer_wr_reg <= reg_wdata[PRTA_XFER_WR_BIT];
				xfer_pend_reg <= 1'b1;
			end
		end
	end
	assign xfer_busy = xfer_pend_reg;

	// Write-back merges staged bytes under their enables onto the old entry
	always_comb begin
		merged = mem_rdata;
		for (int b = 0; b < PRTA_ENTRY_BYTES; b++) begin
			if (be_reg[b + 2])
				merged[b * 8 +: 8] = stage_reg[b * 8 +: 8];
		end
	end

	// Memory addressing: host transfers use the table of the selected port
	always_comb begin
		mem_raddr = AW'((int'(pk_port_reg) - 1) * NRULE + int'(scan_idx_reg));
		if (state_reg == PRTA_S_IDLE && xfer_pend_reg)
			mem_raddr = AW'((int'(ctrl0_reg[3:0]) - 1) * NRULE + int'(xfer_idx_reg));
		else if (state_reg == PRTA_S_IDLE)
			mem_raddr = AW'((int'(pkt_port) - 1) * NRULE);
	end
	assign mem_we = state_reg == PRTA_S_FETCH && xfer_wr_reg;
	assign mem_waddr = AW'((int'(ctrl0_reg[3:0]) - 1) * NRULE + int'(xfer_idx_reg));

	prta_entry_mem #(.WIDTH(EW), .DEPTH(NPORT * NRULE), .AW(AW)) u_mem (
		.clk_sys(clk_sys),
		.wr_en(mem_we),
		.wr_addr(mem_waddr),
		.wr_data(merged),
		.rd_addr(mem_raddr),
		.rd_data(mem_rdata)
	);

	// Host transfers wait only for a running scan to finish
	assign pkt_ready = state_reg == PRTA_S_IDLE && !xfer_pend_reg;

	// Sequencer: transfer fetch/merge, or a sixteen-entry scan
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_reg <= PRTA_S_IDLE;
			scan_idx_reg <= 4'h0;
			pk_port_reg <= 3'h1;
			pk_da_reg <= '0;
			pk_sa_reg <= '0;
			pk_kind_reg <= '0;
		end else begin
			unique case (state_reg)
				PRTA_S_IDLE: begin
					if (xfer_pend_reg) begin
						state_reg <= PRTA_S_FETCH;
					end else if (pkt_valid && pkt_port >= 3'h1 && 4'(pkt_port) <= 4'(NPORT)) begin
						state_reg <= PRTA_S_SCAN;
						scan_idx_reg <= 4'h1;
						pk_port_reg <= pkt_port;
						pk_da_reg <= pkt_dst_addr;
						pk_sa_reg <= pkt_src_addr;
						pk_kind_reg <= pkt_frame_kind;
					end
				end
				PRTA_S_FETCH: state_reg <= PRTA_S_IDLE;
				PRTA_S_SCAN: begin
					scan_idx_reg <= scan_idx_reg + 4'h1;
					if (scan_idx_reg == 4'(NRULE - 1))
						state_reg <= PRTA_S_DRAIN;
				end
				PRTA_S_DRAIN: state_reg <= PRTA_S_IDLE;
				default: state_reg <= PRTA_S_IDLE;
			endcase
		end
	end

	// Entry fields as read back during a scan
	logic [7:0] e_mode, e_act_hi, e_first;
	logic [1:0] e_kind, e_cmp;
	logic [47:0] e_addr, cmp_addr;
	logic [15:0] e_ftype;
	logic addr_eq, kind_eq, e_match;
	prta_cmp_t cmp_kind;
	assign e_mode = stage_byte(mem_rdata, PRTA_OFF_MODE);
	assign e_act_hi = stage_byte(mem_rdata, PRTA_OFF_ACT_HI);
	assign e_first = stage_byte(mem_rdata, PRTA_OFF_FIRST);
	assign e_kind = e_mode[PRTA_KIND_LSB +: 2];
	assign e_cmp = e_mode[PRTA_CMP_LSB +: 2];
	assign e_addr = mem_rdata[(PRTA_ENTRY_BYTES - 8) * 8 +: 48];
	assign e_ftype = mem_rdata[(PRTA_ENTRY_BYTES - 10) * 8 +: 16];
	assign cmp_addr = e_mode[PRTA_SRC_BIT] ? pk_sa_reg : pk_da_reg;
	assign addr_eq = cmp_addr == e_addr;
	assign kind_eq = pk_kind_reg == e_ftype;

	// Comparison decode per kind; network and transport kinds name their test
	always_comb begin
		cmp_kind = PRTA_C_NONE;
		unique case (e_kind)
			PRTA_KIND_STATION: begin
				unique case (e_cmp)
					PRTA_CMP_00: cmp_kind = PRTA_C_COUNT;
					PRTA_CMP_01: cmp_kind = PRTA_C_ADDR;
					PRTA_CMP_10: cmp_kind = PRTA_C_KIND;
					PRTA_CMP_11: cmp_kind = PRTA_C_BOTH;
				endcase
			end
			PRTA_KIND_NETWORK: begin
				if (e_cmp == PRTA_CMP_01)
					cmp_kind = PRTA_C_IP_MASK;
				else if (e_cmp == PRTA_CMP_10)
					cmp_kind = PRTA_C_IP_SA_DA;
			end
			PRTA_KIND_TRANSPORT: begin
				if (e_cmp == PRTA_CMP_00)
					cmp_kind = PRTA_C_PROTO;
				else if (e_cmp == PRTA_CMP_11)
					cmp_kind = PRTA_C_SEQ;
				else
					cmp_kind = PRTA_C_PORTS;
			end
			default: cmp_kind = PRTA_C_NONE;
		endcase
	end

	// Station rules match here; the packet carries no network or transport fields
	always_comb begin
		unique case (cmp_kind)
			PRTA_C_ADDR: e_match = addr_eq == e_mode[PRTA_POL_BIT];
			PRTA_C_KIND: e_match = kind_eq == e_mode[PRTA_POL_BIT];
			PRTA_C_BOTH: e_match = (addr_eq && kind_eq) == e_mode[PRTA_POL_BIT];
			PRTA_C_COUNT: e_match = (addr_eq && kind_eq) == e_mode[PRTA_POL_BIT];
			default: e_match = 1'b0;
		endcase
	end

	// Evaluation pipeline: data for the issued index arrives a cycle later
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			eval_v_reg <= 1'b0;
			eval_idx_reg <= 4'h0;
			match_vec_reg <= '0;
			for (int i = 0; i < NRULE; i++) begin
				set_mask_reg[i] <= 16'h0000;
				frn_reg[i] <= 4'h0;
			end
		end else begin
			eval_v_reg <= (state_reg == PRTA_S_IDLE && pkt_valid && pkt_ready) ||
				state_reg == PRTA_S_SCAN;
			eval_idx_reg <= state_reg == PRTA_S_IDLE ? 4'h0 : scan_idx_reg;
			if (state_reg == PRTA_S_IDLE)
				match_vec_reg <= '0;
			if (eval_v_reg) begin
				match_vec_reg[eval_idx_reg] <= e_match && cmp_kind != PRTA_C_COUNT;
				set_mask_reg[eval_idx_reg] <= {stage_byte(mem_rdata, PRTA_OFF_SET_HI),
					stage_byte(mem_rdata, PRTA_OFF_SET_LO)};
				frn_reg[eval_idx_reg] <= e_first[3:0];
			end
		end
	end

	// Resolve: lowest matching entry whose whole rule set matched wins
	logic res_hit;
	logic [3:0] res_frn;
	always_comb begin
		res_hit = 1'b0;
		res_frn = 4'h0;
		for (int i = NRULE - 1; i >= 0; i--) begin
			if (match_vec_reg[i] && (16'(match_vec_reg) & set_mask_reg[i]) == set_mask_reg[i]) begin
				res_hit = 1'b1;
				res_frn = frn_reg[i];
			end
		end
	end

	// Lookup result, one cycle after the last entry is judged
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			lookup_done <= 1'b0;
			lookup_hit <= 1'b0;
			lookup_action_idx <= 4'h0;
		end else begin
			lookup_done <= state_reg == PRTA_S_IDLE && !eval_v_reg && $past(state_reg) == PRTA_S_DRAIN;
			if (state_reg == PRTA_S_IDLE && $past(state_reg) == PRTA_S_DRAIN) begin
				lookup_hit <= res_hit;
				lookup_action_idx <= res_frn;
			end
		end
	end

	// Time base: microsecond and millisecond ticks
	logic [$clog2(CLKS_PER_US)-1:0] us_cnt_reg;
	logic [$clog2(US_PER_MS)-1:0] ms_cnt_reg;
	logic us_tick, ms_tick;
	assign us_tick = us_cnt_reg == ($clog2(CLKS_PER_US))'(CLKS_PER_US - 1);
	assign ms_tick = us_tick && ms_cnt_reg == ($clog2(US_PER_MS))'(US_PER_MS - 1);
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			us_cnt_reg <= '0;
			ms_cnt_reg <= '0;
		end else begin
			us_cnt_reg <= us_tick ? '0 : us_cnt_reg + 1'b1;
			if (ms_tick)
				ms_cnt_reg <= '0;
			else if (us_tick)
				ms_cnt_reg <= ms_cnt_reg + 1'b1;
		end
	end

	// Packet counting timers, one per port
	logic [PRTA_CNT_W-1:0] tmr_cnt_reg [0:NPORT-1];
	logic [PRTA_CNT_W-1:0] tmr_lim_reg [0:NPORT-1];
	logic [NPORT-1:0] tmr_run_reg, tmr_ms_reg;
	logic tmr_hit;
	logic [PRTA_CNT_W-1:0] hit_count;
	assign tmr_hit = eval_v_reg && cmp_kind == PRTA_C_COUNT && e_match;
	assign hit_count = {e_act_hi[2:0], stage_byte(mem_rdata, PRTA_OFF_ACT_LO)};
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			timer_event <= '0;
			tmr_run_reg <= '0;
			tmr_ms_reg <= '0;
			for (int p = 0; p < NPORT; p++) begin
				tmr_cnt_reg[p] <= '0;
				tmr_lim_reg[p] <= '0;
			end
		end else begin
			for (int p = 0; p < NPORT; p++) begin
				timer_event[p] <= 1'b0;
				if (tmr_hit && int'(pk_port_reg) == p + 1) begin
					tmr_ms_reg[p] <= e_act_hi[PRTA_UNIT_BIT];
					tmr_lim_reg[p] <= hit_count;
					if (!e_act_hi[PRTA_ALG_BIT]) begin
						tmr_cnt_reg[p] <= hit_count;
						tmr_run_reg[p] <= 1'b1;
					end else if (tmr_cnt_reg[p] + 1'b1 >= hit_count) begin
						tmr_cnt_reg[p] <= '0;
						tmr_run_reg[p] <= 1'b0;
						timer_event[p] <= 1'b1;
					end else begin
						tmr_cnt_reg[p] <= tmr_cnt_reg[p] + 1'b1;
						tmr_run_reg[p] <= 1'b0;
					end
				end else if (tmr_run_reg[p] && (tmr_ms_reg[p] ? ms_tick : us_tick)) begin
					if (tmr_cnt_reg[p] <= 11'h001) begin
						tmr_cnt_reg[p] <= '0;
						tmr_run_reg[p] <= 1'b0;
						timer_event[p] <= 1'b1;
					end else begin
						tmr_cnt_reg[p] <= tmr_cnt_reg[p] - 1'b1;
					end
				end
			end
		end
	end

	// Checks
	sequence s_xfer_req;
		loc_wr && ind_addr[7:0] == PRTA_OFF_XFER && port_ok && !xfer_pend_reg &&
			state_reg == PRTA_S_IDLE;
	endsequence
	sequence s_scan_start;
		state_reg == PRTA_S_IDLE && !xfer_pend_reg && pkt_valid && pkt_port >= 3'h1 &&
			4'(pkt_port) <= 4'(NPORT);
	endsequence
	AST_XFER_RUN: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_xfer_req |=> xfer_pend_reg ##1 state_reg == PRTA_S_FETCH ##1 !xfer_pend_reg)
		else $error("entry transfer did not run in three cycles");
	AST_SCAN_LEN: assert property (@(posedge clk_sys) disable iff (!resetn)
		s_scan_start |-> ##18 lookup_done)
		else $error("lookup did not finish eighteen cycles after start");
	AST_OFF_LOW: assert property (@(posedge clk_sys) disable iff (!resetn)
		reg_wr && reg_addr == PRTA_CTRL1_ADDR |=> ind_addr[7:0] == $past(reg_wdata))
		else $error("indirect offset not taken from control one");
	AST_RESV_RD: assert property (@(posedge clk_sys) disable iff (!resetn)
		reg_wr && reg_addr == PRTA_CTRL1_ADDR && tbl_sel && ctrl0_reg[PRTA_RD_BIT] &&
			(reg_wdata == 8'h0E || reg_wdata == 8'h0F) |=> data_reg == 8'h00)
		else $error("reserved offset read nonzero");
	AST_FIRST_HI: assert property (@(posedge clk_sys) disable iff (!resetn)
		reg_wr && reg_addr == PRTA_CTRL1_ADDR && tbl_sel && ctrl0_reg[PRTA_RD_BIT] &&
			reg_wdata == PRTA_OFF_FIRST |=> data_reg[7:4] == 4'h0)
		else $error("upper nibble of offset zero not zero");
	AST_NO_SEL: assert property (@(posedge clk_sys) disable iff (!resetn)
		reg_wr && reg_addr == PRTA_DATA_ADDR && !tbl_sel && state_reg == PRTA_S_IDLE &&
			!xfer_pend_reg |=> $stable(stage_reg) && $stable(be_reg))
		else $error("unselected table written");
	AST_RESV_WR: assert property (@(posedge clk_sys) disable iff (!resetn)
		loc_wr && ind_addr[7:0] == 8'h0E && state_reg != PRTA_S_FETCH |=> $stable(stage_reg))
		else $error("reserved offset write changed the entry");
	AST_TMR_EXP: assert property (@(posedge clk_sys) disable iff (!resetn)
		tmr_run_reg[2] && !tmr_ms_reg[2] && us_tick && tmr_cnt_reg[2] == 11'h001 &&
			!(tmr_hit && pk_port_reg == 3'h3) |=> timer_event[2] && !tmr_run_reg[2])
		else $error("count-down expiry gave no event");
	AST_SRC_SEL: assert property (@(posedge clk_sys) disable iff (!resetn)
		eval_v_reg && cmp_kind == PRTA_C_ADDR && e_mode[PRTA_POL_BIT] &&
			e_addr != pk_sa_reg && e_mode[PRTA_SRC_BIT] |=> !match_vec_reg[$past(eval_idx_reg)])
		else $error("source address rule matched a differing source");
endmodule

// [verification/prta_host.sv]
/*
 Host model: byte cycles on the switch register port, one strobe at a time.
 Assumes the testbench calls its tasks and samples read data itself.
*/
`timescale 1ns/1ps
module prta_host (
	// Clock
	input wire logic clk_sys,
	// Register port
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata
);
	// Idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Control one writes start indirect reads, data byte writes start indirect writes, so order is the caller's job
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_wdata = ~d; // Released lines must not look held
	endtask
	// Read strobe; data lands one cycle later
	task automatic rd(input logic [7:0] a);
		@(negedge clk_sys);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask
endmodule

// [verification/test_packet_rule_table_access.sv]
/*
 Self-checking bench for the rule table: byte access, entry moves, lookups.
 Assumes shortened time-unit parameters; rule memory written before use.
*/
`timescale 1ns/1ps
module test_packet_rule_table_access;
	import prta_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic reg_wr, reg_rd, rd_d, pkt_ready, lookup_done, lookup_hit, xfer_busy;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic pkt_valid = 1'b0;
	logic [2:0] pkt_port = 3'h1;
	logic [47:0] pkt_dst_addr = 48'h0, pkt_src_addr = 48'h0, adr;
	logic [15:0] pkt_frame_kind = 16'h0;
	logic [3:0] lookup_action_idx;
	logic [4:0] timer_event;
	logic [7:0] exp_q[$], cfg[14];
	logic [4:0] lk_q[$], tm_q[$];
	logic [31:0] seed = 32'h055C;
	int errors = 0;
	int num_checks = 0;
	always #5 clk_sys = ~clk_sys;
	prta_host host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	prta_table #(.CLKS_PER_US(2), .US_PER_MS(2)) dut (.clk_sys(clk_sys), .resetn(resetn),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
		.pkt_port(pkt_port), .pkt_dst_addr(pkt_dst_addr), .pkt_src_addr(pkt_src_addr),
		.pkt_frame_kind(pkt_frame_kind), .lookup_done(lookup_done), .lookup_hit(lookup_hit),
		.lookup_action_idx(lookup_action_idx), .timer_event(timer_event), .xfer_busy(xfer_busy));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic results();
		errors += exp_q.size() + lk_q.size() + tm_q.size();
		$display("Checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chkb(input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("Error reg_rdata expected %h seen %h", e, s);
		end
	endtask
	task automatic chkt(input logic [4:0] e, input logic [4:0] s);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("Error timer_event expected %h seen %h", e, s);
		end
	endtask
	// A miss sets the index to zero, but only the hit flag is checked then
	task automatic chkl(input logic [4:0] e, input logic h, input logic [3:0] i);
		num_checks++;
		if (h !== e[4] || (e[4] && i !== e[3:0])) begin
			errors++;
			$display("Error lookup expected %h seen %h", e, {h, i});
		end
	endtask
	task automatic wrb(input logic [3:0] p, input logic [7:0] o, input logic [7:0] d);
		host.wr(PRTA_CTRL0_ADDR, {3'h2, 1'b0, p});
		host.wr(PRTA_CTRL1_ADDR, o);
		host.wr(PRTA_DATA_ADDR, d);
	endtask
	task automatic rdb(input logic [3:0] p, input logic [7:0] o, input logic [7:0] e);
		host.wr(PRTA_CTRL0_ADDR, {3'h2, 1'b1, p});
		host.wr(PRTA_CTRL1_ADDR, o);
		exp_q.push_back(e);
		host.rd(PRTA_DATA_ADDR);
	endtask
	// Entry move through the transfer byte, bounded wait on busy
	task automatic xfer(input logic [7:0] cmd);
		wrb(4'h3, 8'h12, cmd);
		@(negedge clk_sys);
		for (int i = 0; i < 40 && xfer_busy !== 1'b0; i++) @(negedge clk_sys);
		if (xfer_busy !== 1'b0) begin
			errors++;
			results();
		end
	endtask
	task automatic look(input logic [47:0] da, input logic [47:0] sa, input logic [4:0] e);
		@(negedge clk_sys);
		pkt_port = 3'h3;
		pkt_dst_addr = da;
		pkt_src_addr = sa;
		pkt_frame_kind = 16'h0800;
		pkt_valid = 1'b1;
		lk_q.push_back(e);
		for (int i = 0; i < 40 && pkt_ready !== 1'b1; i++) @(negedge clk_sys);
		if (pkt_ready !== 1'b1) begin
			errors++;
			results();
		end
		@(negedge clk_sys);
		pkt_valid = 1'b0;
		pkt_dst_addr = ~da;
		repeat (25) @(negedge clk_sys);
	endtask
	// Results appear in order; oldest note is the one to compare against
	always @(posedge clk_sys) rd_d <= reg_rd;
	always @(negedge clk_sys) begin
		if (rd_d === 1'b1) chkb(exp_q.pop_front(), reg_rdata);
		if (lookup_done === 1'b1) chkl(lk_q.pop_front(), lookup_hit, lookup_action_idx);
		if (timer_event !== 5'h00) chkt(tm_q.pop_front(), timer_event);
	end
	// Watchdog well beyond the roughly seven hundred cycles the sequence needs
	initial begin
		#200000;
		errors++;
		results();
	end
	initial begin
		repeat (12) @(negedge clk_sys);
		resetn = 1'b1;
		for (int o = 0; o < 10; o++) rdb(4'h2, 8'(o), 8'h00);
		wrb(4'h2, 8'h00, 8'hFF);
		rdb(4'h2, 8'h00, 8'h0F);
		wrb(4'h2, 8'h01, 8'hFF);
		rdb(4'h2, 8'h01, 8'h3F);
		wrb(4'h2, 8'h0E, 8'hA5);
		rdb(4'h2, 8'h0E, 8'h00);
		exp_q.push_back(8'h00);
		host.rd(8'h10);
		// Unselected table: only the data byte register takes the write
		host.wr(PRTA_CTRL0_ADDR, 8'h82);
		host.wr(PRTA_DATA_ADDR, 8'h55);
		exp_q.push_back(8'h55);
		host.rd(PRTA_DATA_ADDR);
		exp_q.push_back(8'h82);
		host.rd(PRTA_CTRL0_ADDR);
		rdb(4'h2, 8'h00, 8'h0F);
		// Station rule: address and kind, match on equal, action index 7
		adr = 48'({rnd(), rnd()});
		foreach (cfg[o]) cfg[o] = 8'h00;
		cfg[0] = 8'h07;
		cfg[1] = 8'h1D;
		for (int o = 0; o < 6; o++) cfg[2 + o] = adr[47 - 8 * o -: 8];
		cfg[8] = 8'h08;
		for (int o = 0; o < 14; o++) wrb(4'h3, 8'(o), cfg[o]);
		wrb(4'h3, 8'h10, 8'hFF);
		wrb(4'h3, 8'h11, 8'hFC);
		xfer(8'h10);
		wrb(4'h3, 8'h01, 8'h00);
		for (int i = 1; i < 16; i++) xfer(8'h10 | 8'(i));
		wrb(4'h3, 8'h02, 8'h00);
		xfer(8'h00);
		rdb(4'h3, 8'h02, adr[47:40]);
		rdb(4'h3, 8'h01, 8'h1D);
		look(adr, ~adr, 5'h17);
		look(adr ^ 48'h1, adr, 5'h00);
		// Address only, source side, match on differ
		wrb(4'h3, 8'h01, 8'h16);
		xfer(8'h10);
		look(adr, adr, 5'h00);
		look(adr, adr ^ 48'h100, 5'h17);
		// Address only, source side, match on equal
		wrb(4'h3, 8'h01, 8'h17);
		xfer(8'h10);
		look(adr, adr ^ 48'h100, 5'h00);
		// Entry 1 counts down three microsecond ticks, then counts hits up to two
		wrb(4'h3, 8'h01, 8'h11);
		wrb(4'h3, 8'h0B, 8'h03);
		xfer(8'h11);
		rdb(4'h3, 8'h12, 8'h11);
		rdb(4'h3, 8'h10, 8'hFF);
		tm_q.push_back(5'h04);
		look(adr, adr, 5'h17);
		wrb(4'h3, 8'h0A, 8'h40);
		wrb(4'h3, 8'h0B, 8'h02);
		xfer(8'h11);
		look(adr, adr, 5'h17);
		tm_q.push_back(5'h04);
		look(adr, adr, 5'h17);
		results();
	end
endmodule
